// ### logic/pipc_params.svh
`ifndef PIPC_PARAMS_SVH
`define PIPC_PARAMS_SVH
// register indices; byte address is four times the index
`define PIPC_IDX_CTL0     12'h400
`define PIPC_IDX_CTL1     12'h401
`define PIPC_IDX_RATE     12'h403
`define PIPC_IDX_RLIM     12'h404
`define PIPC_IDX_SLIM     12'h405
`define PIPC_IDX_STAT     12'h406
`define PIPC_IDX_DROPS    12'h407
// writable bit masks, reserved read-only bits stay zero
`define PIPC_CTL0_WMASK   8'h0b
`define PIPC_CTL1_WMASK   8'hbf
`define PIPC_RATE_WMASK   8'h7f
`define PIPC_CTL_RESET    8'h00
`define PIPC_RLIM_RESET   32'hffff_ffff
`define PIPC_SLIM_RESET   16'hffff
// field positions
`define PIPC_BIT_STORM    1
`define PIPC_BIT_BP       3
`define PIPC_BIT_PASS     0
`define PIPC_BIT_PORT     6
`define PIPC_BIT_PPS      5
`define PIPC_BIT_RLFC     4
`define PIPC_MODE_HI      3
`define PIPC_MODE_LO      2
`define PIPC_BIT_IFG      1
`define PIPC_BIT_PRE      0
// byte additions per frame and frame length bounds
`define PIPC_IFG_BYTES    14'h000c
`define PIPC_PRE_BYTES    14'h0008
`define PIPC_MIN_LEN      14'h0040
`define PIPC_MAX_LEN      14'h05f2
// measuring window and bus response codes
`define PIPC_WINDOW_NS    1000000
`define PIPC_CLK_MHZ      125
`define PIPC_RESP_OKAY    2'b00
`define PIPC_RESP_SLVERR  2'b10
`endif

// ### logic/pipc_pkg.sv
package pipc_pkg;
  typedef struct packed {
    logic [13:0] length;
    logic        crc_err;
    logic        bcast;
    logic        mcast;
    logic        flooded;
    logic        pause;
    logic [1:0]  prio;
  } pipc_frame_t;

  typedef struct packed {
    logic forward;
    logic mirror_only;
    logic drop;
    logic counted;
    logic storm_drop;
    logic rate_drop;
  } pipc_verdict_t;

  typedef enum logic [2:0] {
    PIPC_R_CTL0,
    PIPC_R_CTL1,
    PIPC_R_RATE,
    PIPC_R_RLIM,
    PIPC_R_SLIM,
    PIPC_R_STAT,
    PIPC_R_DROPS,
    PIPC_R_NONE
  } pipc_reg_t;
endpackage

// ### logic/pipc_axil_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "pipc_params.svh"
module pipc_axil_slave
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_stb,
  output logic [15:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_err,
  output logic [15:0]      rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_err
);
  logic aw_full_reg;
  logic w_full_reg;
  logic ar_full_reg;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_read;
  logic aw_full_next;
  logic w_full_next;
  logic ar_full_next;
  logic b_next;
  logic r_next;

  ////////////////////////////////////////////////////////////////////////////
  // address and data are taken in either order, the write fires once both held
  assign aw_hs        = s_axi_awvalid & s_axi_awready;
  assign w_hs         = s_axi_wvalid & s_axi_wready;
  assign ar_hs        = s_axi_arvalid & s_axi_arready;
  assign wr_stb       = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign do_read      = ar_full_reg & ~s_axi_rvalid;
  assign aw_full_next = (aw_full_reg & ~wr_stb) | aw_hs;
  assign w_full_next  = (w_full_reg & ~wr_stb) | w_hs;
  assign b_next       = wr_stb | (s_axi_bvalid & ~s_axi_bready);
  assign ar_full_next = (ar_full_reg & ~do_read) | ar_hs;
  assign r_next       = do_read | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      ar_full_reg   <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_bresp   <= `PIPC_RESP_OKAY;
      s_axi_rresp   <= `PIPC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      wr_addr       <= 16'h0000;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
      rd_addr       <= 16'h0000;
    end
    else
    begin
      aw_full_reg   <= aw_full_next;
      w_full_reg    <= w_full_next;
      ar_full_reg   <= ar_full_next;
      s_axi_awready <= ~aw_full_next;
      s_axi_wready  <= ~w_full_next;
      s_axi_arready <= ~ar_full_next & ~r_next;
      s_axi_bvalid  <= b_next;
      s_axi_rvalid  <= r_next;
      if (aw_hs)
        wr_addr <= s_axi_awaddr;
      if (w_hs)
      begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (ar_hs)
        rd_addr <= s_axi_araddr;
      if (wr_stb)
        s_axi_bresp <= wr_err ? `PIPC_RESP_SLVERR : `PIPC_RESP_OKAY;
      if (do_read)
      begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? `PIPC_RESP_SLVERR : `PIPC_RESP_OKAY;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/pipc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pipc_params.svh"
// Summary of operation
// - storm protection only when enable bit set
// - back pressure only half duplex and enabled
// - bad frames dropped unless pass-all, then mirrored
// - pause filtering ignores the pass-all bit
// - port select one per port, zero per priority
// - pps bit counts packets, else bits
// - rate flow control asserted on overrun when enabled
// - also needs port flow control enabled and full duplex
// - mode 00 counts and limits all frames
// - mode 01 broadcast multicast flooded unicast
// - mode 10 broadcast and multicast only
// - mode 11 broadcast only
// - ifg bit adds twelve bytes per frame
// - preamble bit adds eight bytes per frame
// - preamble bit ignored in packet mode
module pipc_top
#(
  parameter int unsigned WINDOW_CYCLES = `PIPC_WINDOW_NS * `PIPC_CLK_MHZ / 1000
)
(
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic [15:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [15:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  frame_valid,
  input  wire pipc_pkg::pipc_frame_t frame_info,
  input  wire logic                  duplex_full,
  input  wire logic                  port_fc_enable,
  input  wire logic                  pause_filter_enable,
  output logic                       verdict_valid,
  output pipc_pkg::pipc_verdict_t    verdict,
  output logic                       flow_ctrl_assert,
  output logic                       back_pressure
);
  logic                    wr_stb;
  logic [15:0]             wr_addr;
  logic [31:0]             wr_data;
  logic [3:0]              wr_strb;
  logic [15:0]             rd_addr;
  logic [31:0]             rd_data;
  logic                    wr_err;
  logic                    rd_err;
  pipc_pkg::pipc_reg_t     wr_sel;
  pipc_pkg::pipc_reg_t     rd_sel;
  logic [7:0]              ctl0_reg;
  logic [7:0]              ctl1_reg;
  logic [7:0]              rate_reg;
  logic [31:0]             rlim_reg;
  logic [15:0]             slim_reg;
  logic [31:0]             slim_wide;
  logic [15:0]             drops_reg;
  logic [31:0]             win_cnt_reg;
  logic [31:0]             rate_cnt_reg [4];
  logic [15:0]             storm_cnt_reg;
  logic                    win_end;
  logic                    storm_en;
  logic                    bp_en;
  logic                    pass_all;
  logic                    rate_port;
  logic                    rate_pps;
  logic                    rate_fc;
  logic [1:0]              limit_mode;
  logic                    cnt_ifg;
  logic                    cnt_pre;
  logic [1:0]              bucket;
  logic [31:0]             units;
  logic                    match;
  logic                    bad;
  logic                    over_idx;
  logic                    over_any;
  logic                    fc_path;
  logic                    bp_path;
  logic                    storm_hit;
  logic                    rate_hit;
  logic                    pause_hit;
  logic                    bad_hit;
  pipc_pkg::pipc_verdict_t verdict_next;

  pipc_axil_slave u_slave
  (
    .clock         (clock),
    .reset_n       (reset_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_stb        (wr_stb),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_err        (wr_err),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_err        (rd_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic pipc_pkg::pipc_reg_t decode(input logic [15:0] addr);
    logic [11:0] idx;
    idx = addr[13:2];
    if (addr[15:14] != 2'b00 || addr[1:0] != 2'b00)
      return pipc_pkg::PIPC_R_NONE;
    case (idx)
      `PIPC_IDX_CTL0:  return pipc_pkg::PIPC_R_CTL0;
      `PIPC_IDX_CTL1:  return pipc_pkg::PIPC_R_CTL1;
      `PIPC_IDX_RATE:  return pipc_pkg::PIPC_R_RATE;
      `PIPC_IDX_RLIM:  return pipc_pkg::PIPC_R_RLIM;
      `PIPC_IDX_SLIM:  return pipc_pkg::PIPC_R_SLIM;
      `PIPC_IDX_STAT:  return pipc_pkg::PIPC_R_STAT;
      `PIPC_IDX_DROPS: return pipc_pkg::PIPC_R_DROPS;
      default:         return pipc_pkg::PIPC_R_NONE;
    endcase
  endfunction

  // byte-lane merge of a write into the current value
  function automatic logic [31:0] merge(input logic [31:0] cur,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = val[i*8 +: 8];
    return res;
  endfunction

  function automatic logic class_match(input logic [1:0]          mode,
                                       input pipc_pkg::pipc_frame_t f);
    case (mode)
      2'b00:   return 1'b1;
      2'b01:   return f.bcast | f.mcast | f.flooded;
      2'b10:   return f.bcast | f.mcast;
      default: return f.bcast;
    endcase
  endfunction

  function automatic logic [31:0] frame_units(input logic        pps,
                                              input logic        ifg,
                                              input logic        pre,
                                              input logic [13:0] len);
    logic [13:0] bytes;
    bytes = len;
    if (pps)
      return 32'h0000_0001;
    if (ifg)
      bytes = bytes + `PIPC_IFG_BYTES;
    if (pre)
      bytes = bytes + `PIPC_PRE_BYTES;
    return {15'h0000, bytes, 3'b000};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign wr_sel     = decode(wr_addr);
  assign rd_sel     = decode(rd_addr);
  assign wr_err     = (wr_sel == pipc_pkg::PIPC_R_NONE);
  assign rd_err     = (rd_sel == pipc_pkg::PIPC_R_NONE);
  assign storm_en   = ctl0_reg[`PIPC_BIT_STORM];
  assign bp_en      = ctl1_reg[`PIPC_BIT_BP];
  assign pass_all   = ctl1_reg[`PIPC_BIT_PASS];
  assign rate_port  = rate_reg[`PIPC_BIT_PORT];
  assign rate_pps   = rate_reg[`PIPC_BIT_PPS];
  assign rate_fc    = rate_reg[`PIPC_BIT_RLFC];
  assign limit_mode = rate_reg[`PIPC_MODE_HI:`PIPC_MODE_LO];
  assign cnt_ifg    = rate_reg[`PIPC_BIT_IFG];
  assign cnt_pre    = rate_reg[`PIPC_BIT_PRE];
  assign slim_wide  = merge({16'h0000, slim_reg}, wr_data, wr_strb);

  always_comb
  begin
    case (rd_sel)
      pipc_pkg::PIPC_R_CTL0:  rd_data = {24'h00_0000, ctl0_reg};
      pipc_pkg::PIPC_R_CTL1:  rd_data = {24'h00_0000, ctl1_reg};
      pipc_pkg::PIPC_R_RATE:  rd_data = {24'h00_0000, rate_reg};
      pipc_pkg::PIPC_R_RLIM:  rd_data = rlim_reg;
      pipc_pkg::PIPC_R_SLIM:  rd_data = {16'h0000, slim_reg};
      pipc_pkg::PIPC_R_STAT:  rd_data = {29'h0000_0000, back_pressure,
                                         flow_ctrl_assert, over_any};
      pipc_pkg::PIPC_R_DROPS: rd_data = {16'h0000, drops_reg};
      default:                rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      ctl0_reg <= `PIPC_CTL_RESET;
      ctl1_reg <= `PIPC_CTL_RESET;
      rate_reg <= `PIPC_CTL_RESET;
      rlim_reg <= `PIPC_RLIM_RESET;
      slim_reg <= `PIPC_SLIM_RESET;
    end
    else if (wr_stb)
    begin
      if (wr_sel == pipc_pkg::PIPC_R_CTL0 && wr_strb[0])
        ctl0_reg <= wr_data[7:0] & `PIPC_CTL0_WMASK;
      if (wr_sel == pipc_pkg::PIPC_R_CTL1 && wr_strb[0])
        ctl1_reg <= wr_data[7:0] & `PIPC_CTL1_WMASK;
      if (wr_sel == pipc_pkg::PIPC_R_RATE && wr_strb[0])
        rate_reg <= wr_data[7:0] & `PIPC_RATE_WMASK;
      if (wr_sel == pipc_pkg::PIPC_R_RLIM)
        rlim_reg <= merge(rlim_reg, wr_data, wr_strb);
      if (wr_sel == pipc_pkg::PIPC_R_SLIM)
        slim_reg <= slim_wide[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame classification and verdict
  assign win_end   = (win_cnt_reg >= WINDOW_CYCLES - 1);
  assign bucket    = rate_port ? 2'b00 : frame_info.prio;
  assign units     = frame_units(rate_pps, cnt_ifg, cnt_pre, frame_info.length);
  assign match     = class_match(limit_mode, frame_info);
  assign bad       = frame_info.crc_err | (frame_info.length > `PIPC_MAX_LEN)
                     | (frame_info.length < `PIPC_MIN_LEN);
  assign over_idx  = (rate_cnt_reg[bucket] >= rlim_reg);
  assign over_any  = rate_port ? (rate_cnt_reg[0] >= rlim_reg)
                     : ((rate_cnt_reg[0] >= rlim_reg) | (rate_cnt_reg[1] >= rlim_reg)
                        | (rate_cnt_reg[2] >= rlim_reg) | (rate_cnt_reg[3] >= rlim_reg));
  assign fc_path   = rate_fc & port_fc_enable & duplex_full;
  assign bp_path   = bp_en & ~duplex_full;
  // the pause filter is decided before and apart from the pass-all bit
  assign pause_hit = frame_info.pause & pause_filter_enable;
  assign bad_hit   = bad & ~pause_hit;
  assign storm_hit = storm_en & frame_info.bcast & (storm_cnt_reg >= slim_reg);
  // with flow control or back pressure active the partner is throttled instead
  assign rate_hit  = match & over_idx & ~fc_path & ~bp_path;

  always_comb
  begin
    verdict_next             = '0;
    verdict_next.counted     = match & ~pause_hit & ~bad_hit;
    verdict_next.storm_drop  = storm_hit & ~pause_hit & ~bad_hit;
    verdict_next.rate_drop   = rate_hit & ~pause_hit & ~bad_hit & ~storm_hit;
    verdict_next.mirror_only = bad_hit & pass_all;
    verdict_next.drop        = pause_hit | (bad_hit & ~pass_all)
                               | verdict_next.storm_drop | verdict_next.rate_drop;
    verdict_next.forward     = ~verdict_next.drop;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      verdict_valid <= 1'b0;
      verdict       <= '0;
      drops_reg     <= 16'h0000;
    end
    else
    begin
      verdict_valid <= frame_valid;
      if (frame_valid)
        verdict <= verdict_next;
      if (frame_valid && verdict_next.drop && drops_reg != 16'hffff)
        drops_reg <= drops_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate and storm counters restart each window
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      win_cnt_reg   <= 32'h0000_0000;
      storm_cnt_reg <= 16'h0000;
      for (int i = 0; i < 4; i++)
        rate_cnt_reg[i] <= 32'h0000_0000;
    end
    else
    begin
      win_cnt_reg <= win_end ? 32'h0000_0000 : win_cnt_reg + 32'h0000_0001;
      if (win_end)
        storm_cnt_reg <= 16'h0000;
      else if (frame_valid && frame_info.bcast && storm_cnt_reg != 16'hffff)
        storm_cnt_reg <= storm_cnt_reg + 16'h0001;
      for (int i = 0; i < 4; i++)
        if (win_end)
          rate_cnt_reg[i] <= 32'h0000_0000;
        else if (frame_valid && verdict_next.counted && bucket == i[1:0])
          rate_cnt_reg[i] <= rate_cnt_reg[i] + units;
    end
  end

  // limitation: throttle levels drop only at a window boundary, on a limit or port-select write or when their path is disabled
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      flow_ctrl_assert <= 1'b0;
      back_pressure    <= 1'b0;
    end
    else
    begin
      flow_ctrl_assert <= fc_path & over_any & ~win_end;
      back_pressure    <= bp_path & over_any & ~win_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  storm_off_a: assert property (frame_valid && !storm_en |=> !verdict.storm_drop)
    else $error("storm drop while protection disabled");
  bp_half_a: assert property (back_pressure |-> $past(!duplex_full && bp_en))
    else $error("back pressure outside half duplex");
  bad_drop_a: assert property (frame_valid && bad && !pass_all && !frame_info.pause
                               |=> verdict.drop && !verdict.mirror_only)
    else $error("bad frame not dropped");
  bad_mirror_a: assert property (frame_valid && bad && pass_all && !pause_hit
                                 |=> verdict.mirror_only && !verdict.drop)
    else $error("bad frame not mirrored");
  pause_filt_a: assert property (frame_valid && pause_hit |=> verdict.drop
                                 && !verdict.mirror_only)
    else $error("pause filter changed by pass-all");
  port_bucket_a: assert property (frame_valid && rate_port && !win_end
                                  |=> rate_cnt_reg[1] == $past(rate_cnt_reg[1]))
    else $error("port mode touched a priority counter");
  pps_unit_a: assert property (frame_valid && rate_pps && verdict_next.counted && !win_end
                               && rate_port |=> rate_cnt_reg[0]
                               == $past(rate_cnt_reg[0]) + 32'h0000_0001)
    else $error("packet mode did not count one");
  fc_gate_a: assert property (flow_ctrl_assert |-> $past(rate_fc && port_fc_enable))
    else $error("flow control without both enables");
  fc_on_a: assert property (fc_path && over_any && !win_end |=> flow_ctrl_assert)
    else $error("flow control missing on overrun");
  bcast_only_a: assert property (limit_mode == 2'b11 && !frame_info.bcast |-> !match)
    else $error("mode 11 matched a non-broadcast frame");
  bypass_a: assert property (frame_valid && !match |=> !verdict.counted
                             && !verdict.rate_drop)
    else $error("unselected frame reached the limiter");
  bytes_a: assert property (!rate_pps && rate_port && frame_valid && verdict_next.counted
                            && !win_end ##1 1'b1 |-> rate_cnt_reg[0] >= $past(units))
    else $error("byte count not added");

  storm_c: cover property (frame_valid ##1 verdict.storm_drop);
  mirror_c: cover property (frame_valid ##1 verdict.mirror_only);
  rate_c: cover property (frame_valid ##1 verdict.rate_drop);
  fc_c: cover property ($rose(flow_ctrl_assert));
endmodule
`default_nettype wire

// ### verification/pipc_link_partner.sv
`timescale 1ns/10ps
`default_nettype none
module pipc_link_partner
(
  input  wire logic             clock,
  output pipc_pkg::pipc_frame_t frame_info,
  output logic                  frame_valid
);
  initial
  begin
    frame_valid = 1'b0;
    frame_info  = '0;
  end
  // call right after a rising edge; the descriptor is junk once its pulse is over,
  // so a design that samples it late sees garbage instead of a lucky match
  task automatic send(input pipc_pkg::pipc_frame_t f);
    frame_valid <= 1'b1;
    frame_info  <= f;
    @(posedge clock);
    frame_valid <= 1'b0;
    frame_info  <= ~f;
  endtask
endmodule
`default_nettype wire

// ### verification/pipc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pipc_top_bench;
  typedef struct packed {logic [7:0] ctl1; logic [7:0] rate; logic pfe;
    pipc_pkg::pipc_frame_t f; logic [5:0] mask; logic [5:0] exp;} pipc_row_t;
  // verdict bits: forward, mirror_only, drop, counted, storm_drop, rate_drop
  localparam pipc_row_t ROWS [13] = '{
    {8'h00, 8'h00, 1'b0, 14'h0100, 7'h00, 6'h38, 6'h20},
    {8'h00, 8'h00, 1'b0, 14'h0100, 7'h40, 6'h18, 6'h08},
    {8'h00, 8'h00, 1'b0, 14'h003f, 7'h00, 6'h18, 6'h08},
    {8'h01, 8'h00, 1'b0, 14'h05f3, 7'h00, 6'h18, 6'h10},
    {8'h01, 8'h00, 1'b1, 14'h0100, 7'h04, 6'h18, 6'h08},
    {8'h01, 8'h00, 1'b0, 14'h0100, 7'h04, 6'h08, 6'h00},
    {8'h00, 8'h00, 1'b0, 14'h0100, 7'h00, 6'h04, 6'h04},
    {8'h00, 8'h04, 1'b0, 14'h0100, 7'h08, 6'h04, 6'h04},
    {8'h00, 8'h04, 1'b0, 14'h0100, 7'h00, 6'h04, 6'h00},
    {8'h00, 8'h08, 1'b0, 14'h0100, 7'h10, 6'h04, 6'h04},
    {8'h00, 8'h08, 1'b0, 14'h0100, 7'h08, 6'h04, 6'h00},
    {8'h00, 8'h0c, 1'b0, 14'h0100, 7'h20, 6'h04, 6'h04},
    {8'h00, 8'h0c, 1'b0, 14'h0100, 7'h10, 6'h04, 6'h00}};
  logic                    clock, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic                    s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic                    s_axi_bvalid, s_axi_arready, s_axi_rvalid, frame_valid;
  logic                    duplex_full, port_fc_enable, pause_filter_enable;
  logic                    verdict_valid, flow_ctrl_assert, back_pressure;
  logic [15:0]             s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  pipc_pkg::pipc_frame_t   frame_info;
  pipc_pkg::pipc_verdict_t verdict, v;
  int                      miscompares = 0;
  int                      n_tests = 0;
  pipc_top #(.WINDOW_CYCLES(1000)) dut (.*);
  pipc_link_partner lp (.clock(clock), .frame_info(frame_info), .frame_valid(frame_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // handshakes are sampled at the falling edge so the decision never races the design
  task automatic axw(input logic [15:0] a, input logic [31:0] d);
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever
    begin
      @(negedge clock);
      {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) break;
    end
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, rv;
    logic [33:0] dr;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever
    begin
      @(negedge clock);
      {ar, rv, dr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge clock);
      if (ar) s_axi_arvalid <= 1'b0;
      if (rv) break;
    end
    s_axi_rready <= 1'b0;
    @(posedge clock);
    check(dr[33:2], ed);
    check(dr[1:0], er);
  endtask
  task automatic frame(input pipc_pkg::pipc_frame_t f);
    lp.send(f);
    @(negedge clock);
    check(verdict_valid, 1'b1);
    v = verdict;
    @(posedge clock);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    print_verdict;
  end
  initial
  begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {port_fc_enable, pause_filter_enable, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    duplex_full = 1'b1;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    rdchk(16'h1000, 32'h0000_0000, 2'b00);
    rdchk(16'h1004, 32'h0000_0000, 2'b00);
    rdchk(16'h100c, 32'h0000_0000, 2'b00);
    rdchk(16'h1010, 32'hffff_ffff, 2'b00);
    rdchk(16'h1020, 32'h0000_0000, 2'b10);
    axw(16'h1004, 32'hffff_ffff);
    rdchk(16'h1004, 32'h0000_00bf, 2'b00);
    $display("test registers done");
    for (int i = 0; i < 13; i++)
    begin
      axw(16'h1004, {24'h0, ROWS[i].ctl1});
      axw(16'h100c, {24'h0, ROWS[i].rate});
      pause_filter_enable <= ROWS[i].pfe;
      frame(ROWS[i].f);
      check(v & ROWS[i].mask, ROWS[i].exp);
    end
    $display("test table done");
    // one packet per window per port: the count left by the table frames already overruns at the first frame
    axw(16'h1010, 32'h0000_0001);
    axw(16'h100c, 32'h0000_0070);
    port_fc_enable <= 1'b1;
    repeat (3) frame({14'h0100, 7'h00});
    check(v[0], 1'b0);
    check(flow_ctrl_assert, 1'b1);
    port_fc_enable <= 1'b0;
    frame({14'h0100, 7'h00});
    check(v[0], 1'b1);
    check(flow_ctrl_assert, 1'b0);
    duplex_full <= 1'b0;
    axw(16'h1004, 32'h0000_0008);
    frame({14'h0100, 7'h00});
    check(back_pressure, 1'b1);
    duplex_full <= 1'b1;
    repeat (2) @(posedge clock);
    check(back_pressure, 1'b0);
    $display("test flow control done");
    axw(16'h1010, 32'hffff_ffff);
    axw(16'h1014, 32'h0000_0001);
    axw(16'h1000, 32'h0000_0002);
    repeat (2) frame({14'h0100, 7'h20});
    check(v[1], 1'b1);
    axw(16'h1000, 32'h0000_0000);
    frame({14'h0100, 7'h20});
    check(v[1], 1'b0);
    $display("test storm done");
    print_verdict;
  end
endmodule
`default_nettype wire
